// >>> two_channel_capture_timer.sv
// Two-channel 16-bit timer with prescaler, modulo counter, capture and compare
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1 - 16-bit up-counter, free-running or modulo with programmed limit
// R2 - Modulo limit comes from high and low limit bytes
// R3 - Reading the counter never disturbs counting
// R4 - Two channels, each independently capture or compare
// R5 - 3-bit select picks seven prescaled bus rates or external clock pin
// R6 - External clock source stays at or below four megahertz
// R7 - Capture triggers on rising, falling or either edge per select bits
// R8 - Capture value held as two 8-bit bytes forming 16 bits
// R9 - Active edge copies counter into channel value registers
// R10 - Every qualifying edge captures even when flag already set
// R11 - Capture sets channel flag; flag and enable raise interrupt
// R12 - Captured value visible two bus cycles after pin event; the capture outputs show it after the fourth rising clock edge
// R13 - Later capture overwrites earlier value, no queue
// R14 - Reset leaves channel value registers unchanged
// R15 - Compare match drives pin high, low or toggles it
// R16 - Option toggles channel pin on each counter overflow
// R17 - Stop bit halts counter; reset bit zeroes counter and prescaler
// R18 - Counter equal to channel value applies pin action, may interrupt
// R19 - Buffer link pairs channels; last-written registers control after overflow
// R20 - Select codes divide bus clock by 1 to 64; code 7 is external
// R21 - Counter wraps to zero past limit and sets overflow flag
module two_channel_capture_timer (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [2:0] clock_source_select_i,
  input wire logic counter_stop_i,
  input wire logic counter_reset_i,
  input wire logic modulo_enable_i,
  input wire logic [7:0] modulo_limit_high_i,
  input wire logic [7:0] modulo_limit_low_i,
  input wire logic overflow_int_enable_i,
  input wire logic overflow_flag_clear_i,
  input wire logic ext_timer_clock_pin_i,
  input wire logic channel0_pin_i,
  input wire logic channel1_pin_i,
  input wire logic [1:0] channel_compare_mode_i,
  input wire logic [1:0] edge_level_select_b_i,
  input wire logic [1:0] edge_level_select_a_i,
  input wire logic [1:0] channel_toggle_on_ovf_i,
  input wire logic [1:0] channel_int_enable_i,
  input wire logic [1:0] channel_flag_clear_i,
  input wire logic buffer_link_select_i,
  input wire logic [1:0] channel_value_write_i,
  input wire logic [7:0] channel_value_high_i,
  input wire logic [7:0] channel_value_low_i,
  output logic [7:0] counter_high_o,
  output logic [7:0] counter_low_o,
  output logic [7:0] capture_value_high0_o,
  output logic [7:0] capture_value_low0_o,
  output logic [7:0] capture_value_high1_o,
  output logic [7:0] capture_value_low1_o,
  output logic channel0_event_flag_o,
  output logic channel1_event_flag_o,
  output logic overflow_flag_o,
  output logic interrupt_o,
  output logic channel0_pin_o,
  output logic channel0_pin_oe_o,
  output logic channel1_pin_o,
  output logic channel1_pin_oe_o
);
  logic [15:0] count;
  logic [5:0] prescale;
  logic ovf_flag;
  logic active_ch1;
  logic pending_ch1;
  logic pending_valid;
  logic [15:0] val_q [2];
  logic [15:0] val_d [2];
  logic [1:0] flag;
  logic [1:0] pin_lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic ext_rise;
  logic [1:0] edge_sel [2];
  logic [1:0] action [2];
  logic [15:0] match [2];
  logic [1:0] mode;
  logic [15:0] limit;
  logic [15:0] wr_value;
  logic [1:0] wr_en;
  logic [5:0] next_prescale;
  logic [15:0] next_count;
  logic ovf_irq;
  logic [1:0] ch_irq;
  logic tick;
  logic at_limit;
  logic ovf;
  logic int_req;

  // External clock and channel pins pass two flops first
  pin_sync u_ext_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(ext_timer_clock_pin_i),
    .level_o(),
    .rise_o(ext_rise),
    .fall_o()
  );

  pin_sync u_ch0_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(channel0_pin_i),
    .level_o(),
    .rise_o(rise[0]),
    .fall_o(fall[0])
  );

  pin_sync u_ch1_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(channel1_pin_i),
    .level_o(),
    .rise_o(rise[1]),
    .fall_o(fall[1])
  );

  // Prescaler tap select: ratios 1..64, code 7 uses external edges
  assign next_prescale = prescale + 6'h01;
  always_comb begin
    unique case (clock_source_select_i)
      3'h0: tick = 1'b1; // R20
      3'h1: tick = prescale[0]; // R20
      3'h2: tick = &prescale[1:0]; // R20
      3'h3: tick = &prescale[2:0]; // R20
      3'h4: tick = &prescale[3:0]; // R20
      3'h5: tick = &prescale[4:0]; // R20
      3'h6: tick = &prescale[5:0]; // R20
      capture_timer_pkg::SRC_EXT: tick = ext_rise; // R5 R6
    endcase
    if (counter_stop_i || counter_reset_i) begin
      tick = 1'b0; // R17
    end
  end

  // Limit is full range when free-running
  assign limit = modulo_enable_i ? {modulo_limit_high_i, modulo_limit_low_i} // R2
                                 : capture_timer_pkg::MAX_COUNT;
  assign at_limit = (count == limit);
  assign ovf = tick && at_limit; // R21

  // Prescaler runs unless stopped; the reset bit clears it
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prescale <= capture_timer_pkg::PRESCALE_RST;
    end else if (counter_reset_i) begin
      prescale <= capture_timer_pkg::PRESCALE_RST; // R17
    end else if (!counter_stop_i) begin
      prescale <= next_prescale; // R17
    end
  end

  // Next count wraps to zero at the limit
  assign next_count = at_limit ? capture_timer_pkg::CNT_RST : count + 16'h0001; // R1 R21

  // Counter steps once per tick; tick is already low while stopped
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= capture_timer_pkg::CNT_RST;
    end else if (counter_reset_i) begin
      count <= capture_timer_pkg::CNT_RST; // R17
    end else if (tick) begin
      count <= next_count; // R1 R21
    end
  end

  // Channel writes and configuration fan-out
  assign wr_value = {channel_value_high_i, channel_value_low_i};
  assign wr_en = channel_value_write_i;
  assign mode = channel_compare_mode_i; // R4

  // Buffered pair: remember which set was written last
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pending_ch1 <= 1'b0;
      pending_valid <= 1'b0;
    end else if (!buffer_link_select_i) begin
      pending_valid <= 1'b0;
    end else if (wr_en[1]) begin
      pending_ch1 <= 1'b1; // R19
      pending_valid <= 1'b1;
    end else if (wr_en[0]) begin
      pending_ch1 <= 1'b0; // R19
      pending_valid <= 1'b1;
    end else if (ovf) begin
      pending_valid <= 1'b0;
    end
  end

  // Buffered pair: switch the active set only at overflow
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_ch1 <= 1'b0;
    end else if (!buffer_link_select_i) begin
      active_ch1 <= 1'b0;
    end else if (ovf && pending_valid) begin
      active_ch1 <= pending_ch1; // R19
    end
  end

  // Channel 0 compares against whichever set is active when linked
  always_comb begin
    match[0] = val_q[0];
    match[1] = val_q[1];
    if (buffer_link_select_i && active_ch1) begin
      match[0] = val_q[1]; // R19
    end
  end

  // Per-channel configuration
  for (genvar i = 0; i < capture_timer_pkg::NUM_CH; i++) begin : g_ch
    assign edge_sel[i] = {edge_level_select_b_i[i], edge_level_select_a_i[i]};
    assign action[i] = {edge_level_select_b_i[i], edge_level_select_a_i[i]};
    timer_channel u_ch (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .count_i(count),
      .tick_i(tick),
      .ovf_i(ovf),
      .compare_mode_i(mode[i]),
      .edge_sel_i(edge_sel[i]),
      .action_i(action[i]),
      .toggle_on_ovf_i(channel_toggle_on_ovf_i[i]),
      .rise_i(rise[i]),
      .fall_i(fall[i]),
      .wr_en_i(wr_en[i]),
      .wr_value_i(wr_value),
      .match_value_i(match[i]),
      .flag_clear_i(channel_flag_clear_i[i]),
      .value_o(val_d[i]),
      .flag_o(flag[i]),
      .pin_level_o(pin_lvl[i])
    );
  end

  // Overflow flag: set wins over clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_flag <= 1'b0;
    end else begin
      ovf_flag <= ovf | (ovf_flag & ~overflow_flag_clear_i); // R21
    end
  end

  // Interrupt sources; channel 1 is silent while linked
  assign ovf_irq = ovf_flag && overflow_int_enable_i; // R21
  assign ch_irq[0] = flag[0] && channel_int_enable_i[0]; // R11
  assign ch_irq[1] = flag[1] && channel_int_enable_i[1] && !buffer_link_select_i; // R11 R19
  assign int_req = ovf_irq || (|ch_irq); // R11

  // Compare copies of the channel values; no reset keeps contents
  always_ff @(posedge clk_sys_i) begin
    val_q[0] <= val_d[0]; // R14
    val_q[1] <= val_d[1]; // R14
  end

  // Read-side capture bytes; no reset keeps contents
  always_ff @(posedge clk_sys_i) begin
    capture_value_high0_o <= val_d[0][15:8]; // R8 R12
    capture_value_low0_o <= val_d[0][7:0]; // R8 R12
    capture_value_high1_o <= val_d[1][15:8]; // R8 R12
    capture_value_low1_o <= val_d[1][7:0]; // R8 R12
  end

  // Counter copy for reading; a side copy never stalls counting
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      counter_high_o <= 8'h00;
      counter_low_o <= 8'h00;
    end else begin
      counter_high_o <= count[15:8]; // R3
      counter_low_o <= count[7:0]; // R3
    end
  end

  // Status flag copies
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      channel0_event_flag_o <= 1'b0;
      channel1_event_flag_o <= 1'b0;
      overflow_flag_o <= 1'b0;
    end else begin
      channel0_event_flag_o <= flag[0]; // R11
      channel1_event_flag_o <= flag[1]; // R11
      overflow_flag_o <= ovf_flag; // R21
    end
  end

  // Interrupt request level
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      interrupt_o <= 1'b0;
    end else begin
      interrupt_o <= int_req; // R11
    end
  end

  // Channel 0 pin, driven only in compare mode
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      channel0_pin_o <= 1'b0;
      channel0_pin_oe_o <= 1'b0;
    end else begin
      channel0_pin_o <= pin_lvl[0];
      channel0_pin_oe_o <= mode[0]; // R15
    end
  end

  // Channel 1 pin, released while the pair is linked
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      channel1_pin_o <= 1'b0;
      channel1_pin_oe_o <= 1'b0;
    end else begin
      channel1_pin_o <= pin_lvl[1];
      channel1_pin_oe_o <= mode[1] && !buffer_link_select_i; // R19
    end
  end
endmodule
`default_nettype wire

// >>> capture_timer_pkg.sv
// Shared constants for the two-channel capture/compare timer
package capture_timer_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 2;
  localparam int SEL_W = 3;
  // Clock source select codes
  localparam logic [2:0] SRC_EXT = 3'h7;
  // Edge/level select codes {b,a}
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  // Compare pin actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // Reset values and the free-running count limit
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [5:0] PRESCALE_RST = 6'h00;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic [15:0] MAX_COUNT = 16'hFFFF;
endpackage

// >>> pin_sync.sv
// Two-flop synchroniser with registered edge detection
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic last;
  // Metastability stages, then one stage for edge history
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end
  assign level_o = sync;
  assign rise_o = sync & ~last;
  assign fall_o = ~sync & last;
endmodule
`default_nettype wire

// >>> timer_channel.sv
// One capture/compare channel: value register, flag and pin logic
`timescale 1ns/100ps
`default_nettype none
module timer_channel (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [15:0] count_i,
  input wire logic tick_i,
  input wire logic ovf_i,
  input wire logic compare_mode_i,
  input wire logic [1:0] edge_sel_i,
  input wire logic [1:0] action_i,
  input wire logic toggle_on_ovf_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_value_i,
  input wire logic [15:0] match_value_i,
  input wire logic flag_clear_i,
  output logic [15:0] value_o,
  output logic flag_o,
  output logic pin_level_o
);
  logic [15:0] value;
  logic flag;
  logic pin_level;
  logic next_pin;
  wire cap_hit;
  wire cmp_hit;
  // Edge qualification per select code
  assign cap_hit = !compare_mode_i &&
                   ((edge_sel_i == capture_timer_pkg::EDGE_RISE && rise_i) ||
                    (edge_sel_i == capture_timer_pkg::EDGE_FALL && fall_i) ||
                    (edge_sel_i == capture_timer_pkg::EDGE_ANY && (rise_i | fall_i))); // R7
  assign cmp_hit = compare_mode_i && tick_i && (count_i == match_value_i); // R18
  // Value register has no reset; capture always overwrites
  always_ff @(posedge clk_sys_i) begin
    if (cap_hit) begin
      value <= count_i; // R9 R10 R13 R14
    end else if (wr_en_i) begin
      value <= wr_value_i;
    end
  end
  // Pin action on match, toggle on overflow
  always_comb begin
    next_pin = pin_level;
    if (cmp_hit) begin
      unique case (action_i)
        capture_timer_pkg::ACT_TOGGLE: next_pin = ~pin_level; // R15
        capture_timer_pkg::ACT_CLEAR: next_pin = 1'b0; // R15
        capture_timer_pkg::ACT_SET: next_pin = 1'b1; // R15
        capture_timer_pkg::ACT_NONE: next_pin = pin_level;
      endcase
    end
    if (compare_mode_i && ovf_i && toggle_on_ovf_i) begin
      next_pin = ~next_pin; // R16
    end
  end
  // Flag: event set wins over clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      flag <= (cap_hit | cmp_hit) | (flag & ~flag_clear_i); // R11
      pin_level <= next_pin;
    end
  end
  assign value_o = value;
  assign flag_o = flag;
  assign pin_level_o = pin_level;
endmodule
`default_nettype wire

// >>> tmr_assertions.sv
// Port assertions for the capture timer
`timescale 1ns/100ps
`default_nettype none
module tmr_chk (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [2:0] clock_source_select_i,
  input wire logic counter_stop_i,
  input wire logic counter_reset_i,
  input wire logic modulo_enable_i,
  input wire logic channel0_pin_i,
  input wire logic [1:0] channel_compare_mode_i,
  input wire logic [1:0] edge_level_select_a_i,
  input wire logic [1:0] channel_flag_clear_i,
  input wire logic buffer_link_select_i,
  input wire logic [7:0] counter_high_o,
  input wire logic [7:0] counter_low_o,
  input wire logic [7:0] capture_value_high0_o,
  input wire logic [7:0] capture_value_low0_o,
  input wire logic channel0_event_flag_o,
  input wire logic channel0_pin_oe_o,
  input wire logic channel1_pin_oe_o
);
  wire logic [15:0] cnt = {counter_high_o, counter_low_o};
  wire logic [15:0] cap0 = {capture_value_high0_o, capture_value_low0_o};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Rising edge seen while channel 0 captures on rise or any edge
  sequence s_rise0;
    !channel_compare_mode_i[0] && edge_level_select_a_i[0] && $rose(channel0_pin_i);
  endsequence
  // Bus clock every cycle, free running
  sequence s_free;
    (clock_source_select_i == 3'h0 && !counter_stop_i && !counter_reset_i
      && !modulo_enable_i)[*3];
  endsequence
  a_count_step: assert property (s_free |=> cnt == $past(cnt) + 16'h0001)
    else $error("counter did not step by one");
  a_capture_flag: assert property (s_rise0 |-> ##4 channel0_event_flag_o)
    else $error("capture flag missing");
  a_capture_time: assert property (s_rise0 |-> ##4 cap0 == $past(cnt))
    else $error("captured value wrong");
  a_flag_sticky: assert property ((!channel_flag_clear_i[0])[*2] ##0 channel0_event_flag_o
    |=> channel0_event_flag_o)
    else $error("flag dropped without clear");
  a_stop_hold: assert property (counter_stop_i[*3] |-> $stable(cnt))
    else $error("counter moved while stopped");
  a_reset_zero: assert property (counter_reset_i[*3] |-> cnt == 16'h0000)
    else $error("counter not held at zero");
  a_capture_no_drive: assert property ((!channel_compare_mode_i[0])[*2] |-> !channel0_pin_oe_o)
    else $error("capture channel drives pin");
  a_link_frees_pin: assert property (buffer_link_select_i[*2] |-> !channel1_pin_oe_o)
    else $error("linked channel 1 drives pin");
endmodule
bind two_channel_capture_timer tmr_chk u_chk (.clk_sys_i, .arst_n_i, .clock_source_select_i,
  .counter_stop_i, .counter_reset_i, .modulo_enable_i, .channel0_pin_i,
  .channel_compare_mode_i, .edge_level_select_a_i, .channel_flag_clear_i,
  .buffer_link_select_i, .counter_high_o, .counter_low_o, .capture_value_high0_o,
  .capture_value_low0_o, .channel0_event_flag_o, .channel0_pin_oe_o, .channel1_pin_oe_o);
`default_nettype wire

// >>> tmr_far_model.sv
// Model of the signals driving the timer pins
`timescale 1ns/100ps
`default_nettype none
module tmr_far (
  input wire logic clk_sys_i,
  output logic ext_clk_o,
  output logic ch0_o,
  output logic ch1_o
);
  initial begin
    ext_clk_o = 1'b0;
    ch0_o = 1'b0;
    ch1_o = 1'b0;
  end
  // Set a capture pin level just after a falling edge
  task automatic set_pin(input int ch, input logic v);
    @(negedge clk_sys_i);
    if (ch == 0) ch0_o = v;
    else ch1_o = v;
  endtask
  // External clock, 260 ns period stays below 4 MHz
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (13) @(negedge clk_sys_i);
      ext_clk_o = 1'b1;
      repeat (13) @(negedge clk_sys_i);
      ext_clk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> test_two_channel_capture_timer.sv
// Testbench for the two-channel capture timer
`timescale 1ns/100ps
`default_nettype none
module test_two_channel_capture_timer;
  logic clk_sys_i = 0, arst_n_i = 0, counter_stop_i = 0, counter_reset_i = 0;
  logic modulo_enable_i = 0, overflow_int_enable_i = 0, overflow_flag_clear_i = 0;
  logic buffer_link_select_i = 0, ext_timer_clock_pin_i, channel0_pin_i, channel1_pin_i;
  logic [2:0] clock_source_select_i = 3'h0;
  logic [7:0] modulo_limit_high_i = 8'h00, modulo_limit_low_i = 8'h10;
  logic [7:0] channel_value_high_i = 8'h00, channel_value_low_i = 8'h00;
  logic [1:0] channel_compare_mode_i = 0, edge_level_select_b_i = 0, edge_level_select_a_i = 0;
  logic [1:0] channel_toggle_on_ovf_i = 0, channel_int_enable_i = 0;
  logic [1:0] channel_flag_clear_i = 0, channel_value_write_i = 0, code;
  logic [7:0] counter_high_o, counter_low_o, capture_value_high0_o, capture_value_low0_o;
  logic [7:0] capture_value_high1_o, capture_value_low1_o;
  logic channel0_event_flag_o, channel1_event_flag_o, overflow_flag_o, interrupt_o;
  logic channel0_pin_o, channel0_pin_oe_o, channel1_pin_o, channel1_pin_oe_o;
  int err_total = 0, n_compared = 0;
  logic [15:0] v0, v1, s[4];
  logic [15:0] e2[4] = '{16'h0010, 16'h0000, 16'h0008, 16'h0000};
  logic [15:0] e3[4] = '{16'h0010, 16'h0010, 16'h0010, 16'h0000};
  wire logic [15:0] cnt = {counter_high_o, counter_low_o};
  wire logic [15:0] cap0 = {capture_value_high0_o, capture_value_low0_o};
  wire logic [15:0] cap1 = {capture_value_high1_o, capture_value_low1_o};
  wire logic [1:0] fl = {channel1_event_flag_o, channel0_event_flag_o};
  two_channel_capture_timer u_dut (.*);
  tmr_far u_far (.clk_sys_i(clk_sys_i), .ext_clk_o(ext_timer_clock_pin_i),
    .ch0_o(channel0_pin_i), .ch1_o(channel1_pin_i));
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Load a channel value register
  task automatic wr_val(input int ch, input logic [15:0] v);
    channel_value_high_i = v[15:8];
    channel_value_low_i = v[7:0];
    channel_value_write_i[ch] = 1'b1;
    tick(1);
    channel_value_write_i = 2'h0;
  endtask
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #300000;
    err_total++;
    summarize();
  end
  // Main sequence
  initial begin
    tick(16);
    arst_n_i = 1'b1;
    for (int k = 0; k < 8; k++) begin
      clock_source_select_i = 3'(k);
      tick(4);
      v0 = cnt;
      if (k == 7) begin
        u_far.ext_pulses(5);
        tick(8);
      end else begin
        tick(128);
      end
      chk(cnt - v0, (k == 7) ? 16'h0005 : 16'(128 >> k));
    end
    clock_source_select_i = 3'h0;
    counter_stop_i = 1'b1;
    tick(3);
    v0 = cnt;
    tick(20);
    chk(cnt, v0);
    counter_stop_i = 1'b0;
    counter_reset_i = 1'b1;
    tick(4);
    chk(cnt, 16'h0000);
    counter_reset_i = 1'b0;
    // Edge modes rise, fall, any, off on both channels
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 4; k++) begin
        code = 2'((k + 1) % 4);
        edge_level_select_b_i[ch] = code[1];
        edge_level_select_a_i[ch] = code[0];
        tick(2);
        for (int i = 0; i < 4; i++) begin
          u_far.set_pin(ch, ~i[0]);
          tick(5);
          s[i] = (ch == 1) ? cap1 : cap0;
          tick(2);
        end
        chk(s[2] - s[1], e2[k]);
        chk(s[3] - s[1], e3[k]);
        channel_int_enable_i[ch] = 1'b1;
        tick(3);
        chk(16'(fl[ch]), 16'(code != 2'h0));
        chk(16'(interrupt_o), 16'(code != 2'h0));
        channel_flag_clear_i[ch] = 1'b1;
        tick(2);
        channel_flag_clear_i = 2'h0;
        tick(4);
        chk(16'(interrupt_o), 16'h0000);
        channel_int_enable_i = 2'h0;
      end
    end
    // Modulo count with a two-byte limit
    modulo_limit_high_i = 8'h01;
    modulo_enable_i = 1'b1;
    overflow_flag_clear_i = 1'b1;
    counter_reset_i = 1'b1;
    tick(2);
    counter_reset_i = 1'b0;
    overflow_flag_clear_i = 1'b0;
    v1 = 16'h0000;
    repeat (600) begin
      tick(1);
      if (cnt > v1) v1 = cnt;
    end
    chk(v1, 16'h0110);
    chk(16'(overflow_flag_o), 16'h0001);
    overflow_int_enable_i = 1'b1;
    tick(3);
    chk(16'(interrupt_o), 16'h0001);
    overflow_int_enable_i = 1'b0;
    // Compare actions set, clear, toggle, then toggle on overflow
    channel_compare_mode_i = 2'h1;
    wr_val(0, 16'h0080);
    for (int j = 0; j < 4; j++) begin
      code = 2'(3 - j);
      edge_level_select_b_i[0] = code[1];
      edge_level_select_a_i[0] = code[0];
      channel_toggle_on_ovf_i[0] = (j == 3);
      tick(300);
      v0 = 16'({channel0_pin_oe_o, channel0_pin_o});
      if (j < 2) begin
        chk(v0, (j == 0) ? 16'h0003 : 16'h0002);
      end else begin
        tick(273);
        chk(16'({channel0_pin_oe_o, channel0_pin_o}), v0 ^ 16'h0001);
      end
    end
    channel_compare_mode_i = 2'h3;
    tick(4);
    chk(16'(channel1_pin_oe_o), 16'h0001);
    buffer_link_select_i = 1'b1;
    tick(4);
    chk(16'(channel1_pin_oe_o), 16'h0000);
    chk(cap0, 16'h0080);
    arst_n_i = 1'b0;
    tick(3);
    arst_n_i = 1'b1;
    tick(2);
    chk(cap0, 16'h0080);
    summarize();
  end
endmodule
`default_nettype wire
